// ===== srs_pkg.sv
package srs_pkg;
	// candidate sync sources, index order is the fallback scan order
	localparam int NSRC = 5;
	localparam logic [2:0] SRC_ADAT = 3'h0;
	localparam logic [2:0] SRC_AES = 3'h1;
	localparam logic [2:0] SRC_SPDIF = 3'h2;
	localparam logic [2:0] SRC_WCTC = 3'h3;
	localparam logic [2:0] SRC_SYNCIN = 3'h4;
	localparam logic [2:0] SRC_NONE = 3'h7;
	// input status codes
	localparam logic [1:0] ST_NOLOCK = 2'h0;
	localparam logic [1:0] ST_LOCK = 2'h1;
	localparam logic [1:0] ST_SYNC = 2'h2;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_INST = 8'h08;
	localparam logic [7:0] REG_IRQ = 8'h0c;
	localparam logic [7:0] REG_MASK = 8'h10;
	localparam logic [7:0] REG_RATE0 = 8'h20;
	// ctrl field positions
	localparam int CTL_AUTO = 0;
	localparam int CTL_PREF = 1;
	localparam int CTL_SPDIN = 4;
	localparam int CTL_SPOPT = 6;
	localparam int CTL_WCBASE = 7;
	localparam int CTL_RATE = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// spdif receiver choices
	localparam logic [1:0] SPIN_OPT = 2'h0;
	localparam logic [1:0] SPIN_COAX = 2'h1;
	localparam logic [1:0] SPIN_INT = 2'h2;
	// sync re-qualification time: consecutive cycles in phase before reporting sync
	localparam int QUAL_US = 10;
	localparam int CLK_MHZ = 20;
	localparam int QUAL_CYC = QUAL_US * CLK_MHZ;
	// top of the base-rate word clock range, same units as the measured rates
	localparam logic [15:0] WC_BASE_MAX = 16'hbb80;
	// status event bits
	localparam int EV_SLAVE = 0;
	localparam int EV_LOST = 1;
	localparam int EV_CHG = 2;
endpackage

// ===== srs_selector.sv
`timescale 1ns/1ps
// Summary of operation
// - auto mode follows valid input at current rate
// - lost reference returns at once to internal
// - preferred input used while valid, else scan
// - no valid candidate means internal master
// - exactly five candidate sources considered
// - all inputs received, only one clocks
// - mode bit picks fixed master or auto
// - measured rate per input is readable
// - report source, master/slave and system rate
// - word clock out optionally base-rate divided
// - selector picks spdif receiver source
// - coax always driven, optical when chosen
// - register writes take effect immediately
// - failed flash boots backup image next power-up
module srs_selector (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic [4:0] src_valid_i,
	input wire logic [4:0] src_inphase_i,
	input wire logic [79:0] src_rate_i,
	input wire logic [4:0] src_clk_en_i,
	input wire logic int_clk_en_i,
	input wire logic [15:0] sys_rate_i,
	input wire logic spdif_opt_i,
	input wire logic spdif_coax_i,
	input wire logic spdif_int_i,
	output logic spdif_rx_o,
	input wire logic spdif_tx_i,
	output logic spdif_coax_o,
	output logic spdif_opt_o,
	input wire logic flash_fail_i,
	input wire logic cold_boot_i,
	output logic boot_backup_o,
	output logic sys_clk_en_o,
	output logic wc_out_o,
	output logic slave_o,
	output logic [2:0] active_src_o
);
	// software control word, applied the cycle it is written
	logic [31:0] ctrl;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [1:0] in_status [5];
	logic [2:0] next_src;
	logic [2:0] cur_src;
	logic [15:0] sys_rate;
	logic wc_div;
	logic fail_seen;
	logic bus_req;
	logic slave_ev;
	logic lost_ev;

	typedef enum logic [1:0] {
		SRS_MASTER = 2'b01,
		SRS_SLAVE = 2'b10
	} srs_state_t;
	srs_state_t state;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// preferred-source field start, short name for the slices below
	localparam int CTL_P = srs_pkg::CTL_PREF;

	// combinational choice: preferred first, then fixed order
	always_comb begin
		next_src = srs_pkg::SRC_NONE;
		for (int i = srs_pkg::NSRC - 1; i >= 0; i--) begin
			if (src_valid_i[i] && src_rate_i[i*16 +: 16] == sys_rate)
				next_src = 3'(i);
		end
		if (ctrl[CTL_P+2:CTL_P] < 3'h5 && src_valid_i[ctrl[CTL_P+2:CTL_P]] &&
			src_rate_i[ctrl[CTL_P+2:CTL_P]*16 +: 16] == sys_rate) begin
			next_src = ctrl[CTL_P+2:CTL_P];
		end
		if (!ctrl[srs_pkg::CTL_AUTO])
			next_src = srs_pkg::SRC_NONE;
	end

	// selection state machine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SRS_MASTER;
			cur_src <= srs_pkg::SRC_NONE;
		end else begin
			case (state)
				SRS_MASTER: begin
					if (next_src != srs_pkg::SRC_NONE) begin
						state <= SRS_SLAVE;
						cur_src <= next_src;
					end
				end
				SRS_SLAVE: begin
					// lost reference, back to internal at once
					if (next_src == srs_pkg::SRC_NONE) begin
						state <= SRS_MASTER;
						cur_src <= srs_pkg::SRC_NONE;
					end else begin
						cur_src <= next_src;
					end
				end
				default: begin
					state <= SRS_MASTER;
					cur_src <= srs_pkg::SRC_NONE;
				end
			endcase
		end
	end
	assign slave_ev = (state == SRS_MASTER) && (next_src != srs_pkg::SRC_NONE);
	assign lost_ev = (state == SRS_SLAVE) && (next_src == srs_pkg::SRC_NONE);

	// one tick source; swap only on registered select
	// so each output tick comes whole from exactly one enable
	always_comb begin
		if (state == SRS_SLAVE && cur_src < 3'h5)
			sys_clk_en_o = src_clk_en_i[cur_src];
		else
			sys_clk_en_o = int_clk_en_i;
	end

	// system rate: rate of the input being picked, else own setting;
	// following the pick, not the old source, keeps the rate steady across
	// a source swap, so a dead source never drags the rate off and fakes a loss
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sys_rate <= 16'h0000;
		else if (next_src < 3'h5)
			sys_rate <= src_rate_i[next_src*16 +: 16];
		else
			sys_rate <= sys_rate_i;
	end

	// per-input status with re-qualification counter
	genvar g;
	generate
		for (g = 0; g < srs_pkg::NSRC; g++) begin : g_in
			logic [15:0] qcnt;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					qcnt <= 16'h0000;
					in_status[g] <= srs_pkg::ST_NOLOCK;
				end else if (!src_valid_i[g]) begin
					qcnt <= 16'h0000;
					in_status[g] <= srs_pkg::ST_NOLOCK;
				end else if (!src_inphase_i[g]) begin
					qcnt <= 16'h0000;
					in_status[g] <= srs_pkg::ST_LOCK;
				end else if (qcnt < 16'(srs_pkg::QUAL_CYC)) begin
					qcnt <= qcnt + 16'h0001;
					in_status[g] <= srs_pkg::ST_LOCK;
				end else begin
					in_status[g] <= srs_pkg::ST_SYNC;
				end
			end
		end
	endgenerate

	// word clock, toggled per tick, halved above base range when the base bit is set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wc_div <= 1'b0;
			wc_out_o <= 1'b0;
		end else if (sys_clk_en_o) begin
			wc_div <= ~wc_div;
			if (!ctrl[srs_pkg::CTL_WCBASE] || sys_rate <= srs_pkg::WC_BASE_MAX)
				wc_out_o <= ~wc_out_o;
			else if (wc_div)
				wc_out_o <= ~wc_out_o;
		end
	end

	always_comb begin
		case (ctrl[srs_pkg::CTL_SPDIN +: 2])
			srs_pkg::SPIN_OPT: spdif_rx_o = spdif_opt_i;
			srs_pkg::SPIN_COAX: spdif_rx_o = spdif_coax_i;
			srs_pkg::SPIN_INT: spdif_rx_o = spdif_int_i;
			default: spdif_rx_o = spdif_coax_i;
		endcase
		spdif_coax_o = spdif_tx_i;
		spdif_opt_o = ctrl[srs_pkg::CTL_SPOPT] & spdif_tx_i;
	end

	// failure remembered, backup used from next cold boot
	// cold boot reloads the image choice; reset clears it back to the main image
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail_seen <= 1'b0;
			boot_backup_o <= 1'b0;
		end else begin
			if (flash_fail_i)
				fail_seen <= 1'b1;
			if (cold_boot_i) begin
				boot_backup_o <= fail_seen | flash_fail_i;
				fail_seen <= flash_fail_i;
			end
		end
	end

	// bus writes and ack; no commit stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			ctrl <= srs_pkg::CTRL_RST;
			irq_mask <= 3'h0;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && wb_we_i) begin
				if (wb_adr_i == srs_pkg::REG_CTRL) begin
					for (int b = 0; b < 4; b++)
						if (wb_sel_i[b])
							ctrl[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
				if (wb_adr_i == srs_pkg::REG_MASK && wb_sel_i[0])
					irq_mask <= wb_dat_i[2:0];
			end
		end
	end

	// sticky events, set beats write-one-to-clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 3'h0;
		end else begin
			for (int e = 0; e < 3; e++) begin
				if ((e == srs_pkg::EV_SLAVE && slave_ev) ||
					(e == srs_pkg::EV_LOST && lost_ev) ||
					(e == srs_pkg::EV_CHG && state == SRS_SLAVE && next_src != cur_src &&
					next_src != srs_pkg::SRC_NONE))
					irq_stat[e] <= 1'b1;
				else if (bus_req && wb_we_i && wb_adr_i == srs_pkg::REG_IRQ && wb_sel_i[0] &&
					wb_dat_i[e])
					irq_stat[e] <= 1'b0;
			end
		end
	end
	assign irq_o = |(irq_stat & irq_mask);

	// read data registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req) begin
			wb_dat_o <= 32'h0000_0000;
			// measured input rates; source and mode
			if (wb_adr_i == srs_pkg::REG_CTRL)
				wb_dat_o <= ctrl;
			else if (wb_adr_i == srs_pkg::REG_STAT)
				wb_dat_o <= {sys_rate, 12'h000, cur_src, state == SRS_SLAVE};
			else if (wb_adr_i == srs_pkg::REG_INST)
				wb_dat_o <= {22'h0, in_status[4], in_status[3], in_status[2], in_status[1],
					in_status[0]};
			else if (wb_adr_i == srs_pkg::REG_IRQ)
				wb_dat_o <= {29'h0, irq_stat};
			else if (wb_adr_i == srs_pkg::REG_MASK)
				wb_dat_o <= {29'h0, irq_mask};
			else if (wb_adr_i >= srs_pkg::REG_RATE0 && wb_adr_i < 8'h34 && wb_adr_i[1:0] == 2'h0)
				wb_dat_o <= {16'h0, src_rate_i[(32'(wb_adr_i - srs_pkg::REG_RATE0) >> 2)*16 +: 16]};
		end
	end

	assign slave_o = (state == SRS_SLAVE);
	assign active_src_o = cur_src;

	// assertions
	property p_back;
		@(posedge clk_i) disable iff (rst_i) lost_ev |=> state == SRS_MASTER && !slave_o;
	endproperty
	a_back: assert property (p_back) else $error("no return to master");
	property p_follow;
		@(posedge clk_i) disable iff (rst_i) slave_ev |=> slave_o && active_src_o == $past(next_src);
	endproperty
	a_follow: assert property (p_follow) else $error("did not follow input");
	property p_none;
		@(posedge clk_i) disable iff (rst_i) src_valid_i == 5'h0 |=> !slave_o;
	endproperty
	a_none: assert property (p_none) else $error("slave with no input");
	property p_manual;
		@(posedge clk_i) disable iff (rst_i) !ctrl[0] |=> !slave_o;
	endproperty
	a_manual: assert property (p_manual) else $error("slave in master mode");
	property p_range;
		@(posedge clk_i) disable iff (rst_i) active_src_o < 3'h5 || active_src_o == 3'h7;
	endproperty
	a_range: assert property (p_range) else $error("bad source index");
	property p_coax;
		@(posedge clk_i) disable iff (rst_i) spdif_coax_o == spdif_tx_i;
	endproperty
	a_coax: assert property (p_coax) else $error("coax not driven");
	property p_nolock;
		@(posedge clk_i) disable iff (rst_i) !src_valid_i[0] |=> in_status[0] == 2'h0;
	endproperty
	a_nolock: assert property (p_nolock) else $error("status not cleared");
	property p_ack;
		@(posedge clk_i) disable iff (rst_i) bus_req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	c_slave: cover property (@(posedge clk_i) slave_ev);
	c_lost: cover property (@(posedge clk_i) lost_ev);
	c_sync: cover property (@(posedge clk_i) in_status[0] == 2'h2);
endmodule

// ===== srs_selector_tb.sv
`timescale 1ns/1ps
module srs_selector_tb;
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, phcfg = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd, dato;
	logic [4:0] vcfg = 5'h00, sv, sph, sce;
	logic [15:0] rate = 16'hbb80, prate = 16'hbb80; // system and source rate
	logic [2:0] sp = 3'h0, act; // receiver lines: opt, coax, internal
	logic tx = 0, ffail = 0, cboot = 0, ack, irq, rx, coax, opt, bk, sclk, wc, slv, ice;
	logic [79:0] srt;
	int num_errors = 0, check_count = 0, cycles = 0;
	initial forever #25 clk_i = ~clk_i;
	srs_src_model far (.clk_i(clk_i), .rst_i(rst_i), .valid_cfg_i(vcfg), .inphase_cfg_i(phcfg),
		.rate_cfg_i(prate), .src_valid_o(sv), .src_inphase_o(sph), .src_rate_o(srt),
		.src_clk_en_o(sce), .int_clk_en_o(ice));
	srs_selector uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_dat_o(dato), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_ack_o(ack), .irq_o(irq), .src_valid_i(sv), .src_inphase_i(sph), .src_rate_i(srt),
		.src_clk_en_i(sce), .int_clk_en_i(ice), .sys_rate_i(rate), .spdif_opt_i(sp[0]),
		.spdif_coax_i(sp[1]), .spdif_int_i(sp[2]), .spdif_rx_o(rx), .spdif_tx_i(tx),
		.spdif_coax_o(coax), .spdif_opt_o(opt), .flash_fail_i(ffail), .cold_boot_i(cboot),
		.boot_backup_o(bk), .sys_clk_en_o(sclk), .wc_out_o(wc), .slave_o(slv),
		.active_src_o(act));
	task finish_test;
		if (num_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one classic cycle; request held until ack is seen at an edge,
	// no answer time assumed: only the bench timeout ends the wait
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(a, 0, 32'h0);
		chk(rd, e);
	endtask
	task tick(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	// counts word clock edges over 20 internal ticks
	task wccount(input int e);
		logic p;
		int t;
		t = 0;
		p = wc;
		repeat (80) begin
			@(posedge clk_i);
			if (wc !== p)
				t++;
			p = wc;
		end
		chk(t, e);
	endtask
	// a hang counts as a mismatch
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			finish_test;
		end
	end
	initial begin
		tick(10);
		rst_i <= 0;
		tick(1);
		chk(act, srs_pkg::SRC_NONE);
		rdchk(srs_pkg::REG_CTRL, srs_pkg::CTRL_RST);
		rdchk(srs_pkg::REG_STAT, {rate, 12'h000, 3'h7, 1'b0});
		// unmapped place reads zero
		rdchk(8'h40, 32'h0);
		vcfg <= 5'h1f;
		wb(srs_pkg::REG_CTRL, 1, 32'h0);
		tick(5);
		chk(slv, 0);
		wb(srs_pkg::REG_CTRL, 1, 32'h3);
		tick(5);
		chk(act, srs_pkg::SRC_AES);
		chk(slv, 1);
		repeat (12) begin
			@(posedge clk_i);
			chk(sclk, sce[1]);
		end
		rdchk(srs_pkg::REG_STAT, {rate, 12'h000, 3'h1, 1'b1});
		vcfg <= 5'h1d;
		tick(5);
		chk(act, srs_pkg::SRC_ADAT);
		wb(srs_pkg::REG_MASK, 1, 32'h0);
		vcfg <= 5'h00;
		tick(3);
		chk(slv, 0);
		chk(act, srs_pkg::SRC_NONE);
		chk(irq, 0);
		rdchk(srs_pkg::REG_IRQ, 32'h7);
		wb(srs_pkg::REG_MASK, 1, 32'h2);
		tick(1);
		chk(irq, 1);
		wb(srs_pkg::REG_IRQ, 1, 32'h7);
		tick(1);
		chk(irq, 0);
		// preferred stays first input; each other input alone is found by the scan
		wb(srs_pkg::REG_CTRL, 1, 32'h1);
		for (int i = 0; i < 5; i++) begin
			vcfg <= 5'h01 << i;
			tick(8);
			chk(act, i);
		end
		// from master, a valid input at another rate is not followed
		vcfg <= 5'h00;
		rate <= 16'hac44;
		tick(4);
		vcfg <= 5'h1f;
		tick(8);
		chk(slv, 0);
		rate <= 16'hbb80;
		tick(4);
		chk(slv, 1);
		vcfg <= 5'h15;
		tick(5);
		rdchk(srs_pkg::REG_INST, 32'h111);
		phcfg <= 1;
		tick(250);
		rdchk(srs_pkg::REG_INST, 32'h222);
		for (int i = 0; i < 5; i++) begin
			rdchk(srs_pkg::REG_RATE0 + 8'(4 * i), {16'h0, i % 2 ? ~prate : prate});
		end
		tx <= 1;
		for (int i = 0; i < 3; i++) begin
			sp <= 3'h1 << i;
			wb(srs_pkg::REG_CTRL, 1, {25'h0, 1'b1, i[1:0], 4'h0});
			tick(1);
			chk(rx, 1);
			chk(opt, 1);
			sp <= ~(3'h1 << i);
			tick(2);
			chk(rx, 0);
		end
		wb(srs_pkg::REG_CTRL, 1, 32'h0);
		tick(1);
		chk(opt, 0);
		chk(coax, 1);
		wccount(20);
		wb(srs_pkg::REG_CTRL, 1, 32'h80);
		wccount(20);
		rate <= 16'hffff;
		tick(2);
		wccount(10);
		ffail <= 1;
		tick(1);
		ffail <= 0;
		tick(3);
		chk(bk, 0);
		cboot <= 1;
		tick(1);
		cboot <= 0;
		tick(3);
		chk(bk, 1);
		// a second reset in mid-run brings back the reset state
		rst_i <= 1;
		tick(2);
		rst_i <= 0;
		tick(1);
		chk(bk, 0);
		chk(wc, 0);
		chk(slv, 0);
		chk(act, srs_pkg::SRC_NONE);
		rdchk(srs_pkg::REG_CTRL, srs_pkg::CTRL_RST);
		finish_test;
	end
endmodule

// ===== srs_src_model.sv
`timescale 1ns/1ps
// far side: lock, phase, measured rate and clock ticks of each input
module srs_src_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] valid_cfg_i,
	input wire logic inphase_cfg_i,
	input wire logic [15:0] rate_cfg_i,
	output logic [4:0] src_valid_o,
	output logic [4:0] src_inphase_o,
	output logic [79:0] src_rate_o,
	output logic [4:0] src_clk_en_o,
	output logic int_clk_en_o
);
	logic [7:0] cnt; // free running tick base
	// tick base, restarts with reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
	// each input ticks at its own period so a wrong pick shows at the tick output
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			src_clk_en_o[i] = valid_cfg_i[i] && ((cnt % (i + 2)) == 0);
			// a dead input shows a wrong rate, never the last good one
			src_rate_o[16*i +: 16] = valid_cfg_i[i] ? rate_cfg_i : ~rate_cfg_i;
		end
	end
	assign src_valid_o = valid_cfg_i;
	assign src_inphase_o = valid_cfg_i & {5{inphase_cfg_i}}; // phase only with lock
	assign int_clk_en_o = (cnt[1:0] == 2'h0); // internal tick every 4 cycles
endmodule
